//--- rcp_pkg.sv
`default_nettype none
package rcp_pkg;

  localparam int PIX_W  = 12;
  localparam int DIM_W  = 13;
  localparam int SUM_W  = DIM_W + 1;
  localparam int ADDR_W = 8;
  localparam int FRM_W  = 12;

  // Sensor array limits and window granularity
  localparam logic [DIM_W-1:0] MAX_COLS    = 13'h1000;
  localparam logic [DIM_W-1:0] MAX_LINES   = 13'h1000;
  localparam logic [DIM_W-1:0] H_STEP_MASK = 13'h000F;
  localparam logic [DIM_W-1:0] V_STEP_MASK = 13'h000F;
  localparam logic [DIM_W-1:0] WIDTH_MIN   = 13'h0010;
  localparam logic [DIM_W-1:0] HEIGHT_MIN  = 13'h0010;
  localparam logic [DIM_W-1:0] START_MIN   = 13'h0000;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_COL_START  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_WIDTH      = 8'h04;
  localparam logic [ADDR_W-1:0] REG_LINE_START = 8'h08;
  localparam logic [ADDR_W-1:0] REG_HEIGHT     = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_PATTERN    = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h14;

  // Reset values
  localparam logic [DIM_W-1:0] RST_COL_START  = 13'h0000;
  localparam logic [DIM_W-1:0] RST_WIDTH      = 13'h1000;
  localparam logic [DIM_W-1:0] RST_LINE_START = 13'h0000;
  localparam logic [DIM_W-1:0] RST_HEIGHT     = 13'h1000;

  // Status fields
  localparam int ST_REFUSED_BIT  = 0;
  localparam int ST_IN_FRAME_BIT = 1;
  localparam int ST_FRAME_LSB    = 16;

  // Pattern source codes
  localparam logic [1:0] PAT_OFF   = 2'h0;
  localparam logic [1:0] PAT_HRAMP = 2'h1;
  localparam logic [1:0] PAT_VRAMP = 2'h2;
  localparam logic [1:0] PAT_DIAG  = 2'h3;

  typedef struct packed {
    logic             sof;
    logic             sol;
    logic [PIX_W-1:0] data;
  } rcp_pix_t;

  typedef struct packed {
    logic             valid;
    logic             sof;
    logic             sol;
    logic             eol;
    logic             eof;
    logic [PIX_W-1:0] data;
  } rcp_vid_t;

  typedef struct packed {
    logic [DIM_W-1:0] window_column_start;
    logic [DIM_W-1:0] width;
    logic [DIM_W-1:0] window_line_start;
    logic [DIM_W-1:0] height;
    logic [1:0]       pattern_source_select;
  } rcp_win_t;

  typedef struct packed {
    rcp_win_t         prog;
    rcp_win_t         act;
    logic [DIM_W-1:0] x;
    logic [DIM_W-1:0] y;
    logic [FRM_W-1:0] frame;
    logic             refused;
    logic             in_frame;
    logic [31:0]      rdata;
    rcp_vid_t         vid;
    logic [DIM_W-1:0] scan_lines;
  } rcp_state_t;

endpackage
`default_nettype wire

//--- rcp_roi_crop.sv
// Summary of operation
// - Frame starts at programmed line start.
// - Exactly programmed height lines are delivered.
// - Only pixels inside window are sent.
// - Fewer lines scanned when height shrinks.
// - Each line starts at column start.
// - Each line holds exactly width pixels.
// - Offset and width obey min, max, step.
// - Pattern replaces pixels right after sensor.
// - Pattern uses full sensor bit depth.
// - Pattern pixels follow sensor pixel path.
// - Correction stages never disabled by pattern.
// - Vertical ramp rises down the frame.
// - Diagonal start value grows each frame.
// - Pattern off passes sensor pixels unchanged.
// - Horizontal ramp rises along each line.
`default_nettype none
module rcp_roi_crop
  import rcp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  input  wire logic              sen_valid,
  input  wire rcp_pix_t          sen_pix,
  output rcp_vid_t               vid_out,
  output logic [DIM_W-1:0]       scan_lines
);

  rcp_state_t       q;
  rcp_state_t       d;
  rcp_win_t         act;
  logic [DIM_W-1:0] cur_x;
  logic [DIM_W-1:0] cur_y;
  logic [FRM_W-1:0] act_frame;
  logic [SUM_W-1:0] col_end;
  logic [SUM_W-1:0] line_end;
  logic             in_win;
  logic             take;
  logic             at_eol;
  logic             at_eof;
  logic [PIX_W-1:0] diag_val;
  logic [PIX_W-1:0] pat_pix;
  logic [DIM_W-1:0] new_val;
  logic             hi_ok;

  function automatic logic fits(
    input logic [DIM_W-1:0] v,
    input logic [DIM_W-1:0] other,
    input logic [DIM_W-1:0] lim,
    input logic [DIM_W-1:0] mask,
    input logic [DIM_W-1:0] vmin
  );
    fits = ((v & mask) == '0) && (v >= vmin)
           && ((SUM_W'(v) + SUM_W'(other)) <= SUM_W'(lim));
  endfunction

  assign reg_rdata  = q.rdata;
  assign vid_out    = q.vid;
  assign scan_lines = q.scan_lines;

  assign new_val = reg_wdata[DIM_W-1:0];
  assign hi_ok   = (reg_wdata[31:DIM_W] == '0);

  // Pixel position in sensor coordinates
  assign cur_x = (sen_pix.sof || sen_pix.sol) ? '0 : q.x + 13'h0001;
  assign cur_y = sen_pix.sof ? '0 : (sen_pix.sol ? q.y + 13'h0001 : q.y);

  // Window and pattern take effect at frame start
  assign act       = sen_pix.sof ? q.prog : q.act;
  assign act_frame = sen_pix.sof ? q.frame + 12'h001 : q.frame;

  assign col_end  = SUM_W'(act.window_column_start) + SUM_W'(act.width);
  assign line_end = SUM_W'(act.window_line_start) + SUM_W'(act.height);

  assign in_win = (cur_x >= act.window_column_start)
                  && (SUM_W'(cur_x) < col_end)
                  && (cur_y >= act.window_line_start)
                  && (SUM_W'(cur_y) < line_end);
  assign take   = sen_valid && in_win;
  assign at_eol = (SUM_W'(cur_x) == col_end - 14'h0001);
  assign at_eof = at_eol && (SUM_W'(cur_y) == line_end - 14'h0001);

  // Diagonal ramp: one step per pixel, origin moves per frame
  assign diag_val = cur_x[PIX_W-1:0] + cur_y[PIX_W-1:0] + act_frame;

  // Source select ahead of all later processing, full depth
  always_comb begin
    unique case (act.pattern_source_select)
      PAT_OFF:   pat_pix = sen_pix.data;
      PAT_HRAMP: pat_pix = cur_x[PIX_W-1:0];
      PAT_VRAMP: pat_pix = cur_y[PIX_W-1:0];
      PAT_DIAG:  pat_pix = diag_val;
    endcase
  end

  always_comb begin
    d         = q;
    d.rdata   = '0;
    d.vid     = '0;
    if (reg_wr) begin
      case (reg_addr)
        REG_COL_START: begin
          if (hi_ok && fits(new_val, q.prog.width, MAX_COLS, H_STEP_MASK, START_MIN)) begin
            d.prog.window_column_start = new_val;
          end else begin
            d.refused = 1'b1;
          end
        end
        REG_WIDTH: begin
          if (hi_ok && fits(new_val, q.prog.window_column_start, MAX_COLS, H_STEP_MASK, WIDTH_MIN)) begin
            d.prog.width = new_val;
          end else begin
            d.refused = 1'b1;
          end
        end
        REG_LINE_START: begin
          if (hi_ok && fits(new_val, q.prog.height, MAX_LINES, V_STEP_MASK, START_MIN)) begin
            d.prog.window_line_start = new_val;
          end else begin
            d.refused = 1'b1;
          end
        end
        REG_HEIGHT: begin
          if (hi_ok && fits(new_val, q.prog.window_line_start, MAX_LINES, V_STEP_MASK, HEIGHT_MIN)) begin
            d.prog.height = new_val;
          end else begin
            d.refused = 1'b1;
          end
        end
        REG_PATTERN: begin
          d.prog.pattern_source_select = reg_wdata[1:0];
        end
        REG_STATUS: begin
          if (reg_wdata[ST_REFUSED_BIT]) begin
            d.refused = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // A set flag stays set on a write to any address other than REG_STATUS
    if (reg_wr && (d.refused != 1'b0) && (reg_addr != REG_STATUS)) begin
      d.refused = 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_COL_START:  d.rdata = 32'(q.prog.window_column_start);
        REG_WIDTH:      d.rdata = 32'(q.prog.width);
        REG_LINE_START: d.rdata = 32'(q.prog.window_line_start);
        REG_HEIGHT:     d.rdata = 32'(q.prog.height);
        REG_PATTERN:    d.rdata = 32'(q.prog.pattern_source_select);
        REG_STATUS: begin
          d.rdata[ST_REFUSED_BIT]           = q.refused;
          d.rdata[ST_IN_FRAME_BIT]          = q.in_frame;
          d.rdata[ST_FRAME_LSB +: FRM_W]    = q.frame;
        end
        default:        d.rdata = '0;
      endcase
    end
    if (sen_valid) begin
      d.x = cur_x;
      d.y = cur_y;
      if (sen_pix.sof) begin
        d.act        = q.prog;
        d.frame      = act_frame;
        d.in_frame   = 1'b1;
        d.scan_lines = line_end[DIM_W-1:0];
      end
      if (in_win) begin
        d.vid.valid = 1'b1;
        d.vid.sof   = (cur_x == act.window_column_start)
                      && (cur_y == act.window_line_start);
        d.vid.sol   = (cur_x == act.window_column_start);
        d.vid.eol   = at_eol;
        d.vid.eof   = at_eof;
        d.vid.data  = pat_pix;
        if (at_eof) begin
          d.in_frame = 1'b0;
        end
      end
    end
  end

  // Flat-field and shading stages sit downstream and keep their own
  // enables; nothing here touches them.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q                            <= '0;
      q.prog.window_column_start   <= RST_COL_START;
      q.prog.width                 <= RST_WIDTH;
      q.prog.window_line_start     <= RST_LINE_START;
      q.prog.height                <= RST_HEIGHT;
      q.act.window_column_start    <= RST_COL_START;
      q.act.width                  <= RST_WIDTH;
      q.act.window_line_start      <= RST_LINE_START;
      q.act.height                 <= RST_HEIGHT;
      q.scan_lines                 <= RST_HEIGHT;
    end else begin
      q <= d;
    end
  end

  // Assertion helpers: pixels and lines already delivered
  logic [DIM_W-1:0] hc_pix;
  logic [DIM_W-1:0] hc_lines;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hc_pix   <= '0;
      hc_lines <= '0;
    end else begin
      if (vid_out.valid) begin
        hc_pix <= vid_out.sol ? 13'h0001 : hc_pix + 13'h0001;
      end
      if (vid_out.valid && vid_out.eol) begin
        hc_lines <= vid_out.eof ? '0 : hc_lines + 13'h0001;
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  AST_FIRST_LINE: assert property (
    vid_out.valid && vid_out.sof |-> $past(cur_y) == $past(act.window_line_start)
  ) else $error("frame began on wrong line");

  AST_LINE_COUNT: assert property (
    vid_out.valid && vid_out.eof |-> hc_lines + 13'h0001 == q.act.height
  ) else $error("line count differs from height");

  AST_ONLY_WINDOW: assert property (
    vid_out.valid |-> $past(take)
  ) else $error("pixel outside window sent");

  AST_WINDOW_SENT: assert property (
    take |=> vid_out.valid
  ) else $error("window pixel dropped");

  AST_SCAN_LINES: assert property (
    sen_valid && sen_pix.sof |=> scan_lines == $past(line_end[DIM_W-1:0])
  ) else $error("scan line count not updated");

  AST_LINE_START: assert property (
    vid_out.valid && vid_out.sol |-> $past(cur_x) == $past(act.window_column_start)
  ) else $error("line began on wrong column");

  AST_PIX_COUNT: assert property (
    vid_out.valid && vid_out.eol |-> (vid_out.sol ? 13'h0001 : hc_pix + 13'h0001) == q.act.width
  ) else $error("pixel count differs from width");

  AST_WIDTH_STEP: assert property (
    reg_wr && reg_addr == REG_WIDTH && (new_val & H_STEP_MASK) != '0
    |=> q.prog.width == $past(q.prog.width) && q.refused
  ) else $error("off-step width accepted");

  AST_WIDTH_EDGE: assert property (
    reg_wr && reg_addr == REG_WIDTH
    && SUM_W'(q.prog.window_column_start) + SUM_W'(new_val) > SUM_W'(MAX_COLS)
    |=> q.prog.width == $past(q.prog.width) && q.refused
  ) else $error("oversized window accepted");

  AST_VRAMP: assert property (
    sen_valid && in_win && act.pattern_source_select == PAT_VRAMP
    |=> vid_out.data == $past(cur_y[PIX_W-1:0])
  ) else $error("vertical ramp value wrong");

  AST_HRAMP: assert property (
    sen_valid && in_win && act.pattern_source_select == PAT_HRAMP
    |=> vid_out.data == $past(cur_x[PIX_W-1:0])
  ) else $error("horizontal ramp value wrong");

  AST_DIAG: assert property (
    sen_valid && in_win && act.pattern_source_select == PAT_DIAG
    |=> vid_out.data == $past(diag_val)
  ) else $error("diagonal ramp value wrong");

  AST_FRAME_STEP: assert property (
    sen_valid && sen_pix.sof |=> q.frame == $past(q.frame) + 12'h001
  ) else $error("frame counter did not advance by one");

  AST_PASS_THRU: assert property (
    sen_valid && in_win && act.pattern_source_select == PAT_OFF
    |=> vid_out.data == $past(sen_pix.data)
  ) else $error("sensor pixel altered");

  AST_VID_IDLE: assert property (
    !take |=> vid_out == '0
  ) else $error("video output active outside window");

  AST_WIDTH_MIN: assert property (
    reg_wr && reg_addr == REG_WIDTH && new_val < WIDTH_MIN
    |=> q.prog.width == $past(q.prog.width) && q.refused
  ) else $error("undersized width accepted");

  AST_COL_EDGE: assert property (
    reg_wr && reg_addr == REG_COL_START
    && SUM_W'(new_val) + SUM_W'(q.prog.width) > SUM_W'(MAX_COLS)
    |=> q.prog.window_column_start == $past(q.prog.window_column_start) && q.refused
  ) else $error("column start past edge accepted");

  AST_LINE_EDGE: assert property (
    reg_wr && reg_addr == REG_LINE_START
    && SUM_W'(new_val) + SUM_W'(q.prog.height) > SUM_W'(MAX_LINES)
    |=> q.prog.window_line_start == $past(q.prog.window_line_start) && q.refused
  ) else $error("line start past edge accepted");

  AST_HEIGHT_MIN: assert property (
    reg_wr && reg_addr == REG_HEIGHT && new_val < HEIGHT_MIN
    |=> q.prog.height == $past(q.prog.height) && q.refused
  ) else $error("undersized height accepted");

  AST_ACT_LATCH: assert property (
    sen_valid && sen_pix.sof |=> q.act == $past(q.prog)
  ) else $error("window not latched at frame start");

  AST_SCAN_HOLD: assert property (
    !(sen_valid && sen_pix.sof) |=> $stable(scan_lines)
  ) else $error("scan line count moved mid-frame");

  AST_FRAME_DONE: assert property (
    vid_out.valid && vid_out.eof |-> !q.in_frame
  ) else $error("frame flag still set after last line");

  COV_VRAMP:      cover property (vid_out.valid && vid_out.sof && q.act.pattern_source_select == PAT_VRAMP);
  COV_FULL_FRAME: cover property (vid_out.valid && vid_out.eof);
  COV_REFUSE:     cover property (reg_wr ##1 q.refused);
  COV_DIAG_FRAME: cover property (sen_valid && sen_pix.sof && q.prog.pattern_source_select == PAT_DIAG);
  COV_CROPPED:    cover property (vid_out.valid && vid_out.sol && q.act.window_column_start != '0);

endmodule
`default_nettype wire

//--- rcp_host_model.sv
`default_nettype none
module rcp_host_model
  import rcp_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire rcp_vid_t         vid,
  input  wire logic [DIM_W-1:0] exp_w,
  input  wire logic [DIM_W-1:0] exp_h,
  output logic [15:0]           frames,
  output logic [31:0]           total,
  output logic [PIX_W-1:0]      first_pix,
  output logic [PIX_W-1:0]      last_pix,
  output logic                  incomplete
);
  timeunit 1ns;
  timeprecision 1ps;
  int lp;
  int ln;
  int tot;
  // Buffer sized to the window; any size slip marks the buffer incomplete
  always @(posedge ref_clk) begin
    if (reset) begin
      frames <= 16'h0000;
      incomplete <= 1'b0;
      lp = 0;
      ln = 0;
      tot = 0;
    end else if (vid.valid) begin
      if (vid.sof) begin
        ln = 0;
        tot = 0;
        first_pix <= vid.data;
      end
      if (vid.sol) begin
        lp = 0;
      end
      lp++;
      tot++;
      if (vid.eol) begin
        ln++;
        if (lp != int'(exp_w)) incomplete <= 1'b1;
      end
      if (vid.eof) begin
        last_pix <= vid.data;
        total <= 32'(tot);
        frames <= frames + 16'h0001;
        if (ln != int'(exp_h)) incomplete <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
`default_nettype none
module tb_top
  import rcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk;
  logic              reset;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic              sen_valid;
  rcp_pix_t          sen_pix;
  rcp_vid_t          vid_out;
  logic [DIM_W-1:0]  scan_lines;
  logic [DIM_W-1:0]  exp_w;
  logic [DIM_W-1:0]  exp_h;
  logic [15:0]       frames;
  logic [31:0]       total;
  logic [PIX_W-1:0]  first_pix;
  logic [PIX_W-1:0]  last_pix;
  logic              incomplete;
  logic [31:0]       rd_val;
  int                fails;
  int                samples_checked;
  int                sofs;

  rcp_roi_crop dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sen_valid(sen_valid),
    .sen_pix(sen_pix), .vid_out(vid_out), .scan_lines(scan_lines));
  rcp_host_model host (.ref_clk(ref_clk), .reset(reset), .vid(vid_out), .exp_w(exp_w), .exp_h(exp_h),
    .frames(frames), .total(total), .first_pix(first_pix), .last_pix(last_pix), .incomplete(incomplete));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  function automatic logic [PIX_W-1:0] sv(input logic [5:0] x, input logic [5:0] y);
    return {y, x};
  endfunction

  // Sensor frame of 48 x 40 with a one-cycle stall in every line
  task automatic run_frame();
    logic [15:0] f0;
    int n;
    f0 = frames;
    sofs++;
    for (int y = 0; y < 40; y++) begin
      for (int x = 0; x < 48; x++) begin
        @(posedge ref_clk);
        if (x == 3) begin
          sen_valid <= 1'b0;
          @(posedge ref_clk);
        end
        sen_valid <= 1'b1;
        sen_pix <= '{sof: (x == 0 && y == 0), sol: (x == 0 && y != 0), data: sv(x[5:0], y[5:0])};
      end
    end
    @(posedge ref_clk);
    sen_valid <= 1'b0;
    n = 0;
    while (frames == f0 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (frames == f0) begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic t_reset();
    rd_chk(REG_COL_START, 32'(RST_COL_START));
    rd_chk(REG_WIDTH, 32'(RST_WIDTH));
    rd_chk(REG_LINE_START, 32'(RST_LINE_START));
    rd_chk(REG_HEIGHT, 32'(RST_HEIGHT));
    rd_chk(REG_PATTERN, 32'h0);
    rd_chk(REG_STATUS, 32'h0);
    chk(32'(scan_lines), 32'(MAX_LINES));
  endtask

  task automatic t_window(input logic [31:0] cs, input logic [31:0] w, input logic [31:0] ls,
                          input logic [31:0] h);
    // Sizes first so the old sizes never push the new offsets past the edge
    wr(REG_WIDTH, w);
    wr(REG_HEIGHT, h);
    wr(REG_COL_START, cs);
    wr(REG_LINE_START, ls);
    exp_w <= w[DIM_W-1:0];
    exp_h <= h[DIM_W-1:0];
    run_frame();
    chk(total, w * h);
    chk(32'(first_pix), 32'(sv(cs[5:0], ls[5:0])));
    chk(32'(last_pix), 32'(sv(6'(cs + w - 1), 6'(ls + h - 1))));
    chk(32'(incomplete), 32'h0);
    chk(32'(scan_lines), ls + h);
  endtask

  task automatic t_refuse();
    logic [31:0] bad [4];
    bad = '{32'h18, 32'h8, 32'h2000, 32'h1000};
    foreach (bad[i]) begin
      wr(REG_WIDTH, bad[i]);
      rd_chk(REG_WIDTH, 32'h10);
      rd(REG_STATUS, rd_val);
      chk(rd_val & 32'h1, 32'h1);
      wr(REG_STATUS, 32'h1);
      rd(REG_STATUS, rd_val);
      chk(rd_val & 32'h1, 32'h0);
    end
    wr(REG_COL_START, 32'hFF0);
    rd_chk(REG_COL_START, 32'hFF0);
    wr(REG_COL_START, 32'h1000);
    rd_chk(REG_COL_START, 32'hFF0);
    wr(REG_LINE_START, 32'hFF0);
    rd_chk(REG_LINE_START, 32'h0);
    wr(REG_HEIGHT, 32'h8);
    rd_chk(REG_HEIGHT, 32'h20);
    rd(REG_STATUS, rd_val);
    chk(rd_val & 32'h1, 32'h1);
    wr(8'h20, 32'h5);
    rd_chk(8'h20, 32'h0);
  endtask

  task automatic t_pattern();
    logic [PIX_W-1:0] f1;
    wr(REG_PATTERN, 32'(PAT_HRAMP));
    run_frame();
    chk(32'(first_pix), 32'h20);
    chk(32'(last_pix), 32'h2F);
    wr(REG_PATTERN, 32'(PAT_VRAMP));
    run_frame();
    chk(32'(first_pix), 32'h10);
    chk(32'(last_pix), 32'h1F);
    wr(REG_PATTERN, 32'(PAT_DIAG));
    run_frame();
    f1 = first_pix;
    run_frame();
    chk(32'(first_pix - f1), 32'h1);
    chk(32'(last_pix - first_pix), 32'h1E);
    chk(32'(incomplete), 32'h0);
    rd(REG_STATUS, rd_val);
    chk(rd_val >> ST_FRAME_LSB, 32'(sofs));
    chk(rd_val & 32'h2, 32'h0);
  endtask

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sen_valid = 1'b0;
    sen_pix = '0;
    exp_w = 13'h010;
    exp_h = 13'h010;
    fails = 0;
    samples_checked = 0;
    sofs = 0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_window(32'h10, 32'h10, 32'h10, 32'h10);
    t_window(32'h20, 32'h10, 32'h0, 32'h20);
    t_refuse();
    t_window(32'h20, 32'h10, 32'h10, 32'h10);
    t_pattern();
    give_verdict();
  end
endmodule
`default_nettype wire
